// ===== src/quad_decoder_integration.sv
`include "quad_integ_defs.svh"

module quad_decoder_integration (
	input  wire logic                 clk_sys,        // Peripheral clock, 50 MHz
	input  wire logic                 sys_rst,        // Async reset, high
	input  wire logic                 clkEnable,      // Freezes all state when low
	input  wire quad_integ_pkg::pins_t pinsA,         // Phase A pin per decoder
	input  wire quad_integ_pkg::pins_t pinsB,         // Phase B pin per decoder
	input  wire quad_integ_pkg::pins_t pinsI,         // Index pin per decoder
	input  wire quad_integ_pkg::pins_t pinsS,         // Strobe pin per decoder
	input  wire logic [11:0]          s_axi_awaddr,   // Write address
	input  wire logic                 s_axi_awvalid,  // Write address valid
	output logic                      s_axi_awready,  // Write address ready
	input  wire logic [31:0]          s_axi_wdata,    // Write data
	input  wire logic [3:0]           s_axi_wstrb,    // Byte enables
	input  wire logic                 s_axi_wvalid,   // Write data valid
	output logic                      s_axi_wready,   // Write data ready
	output logic [1:0]                s_axi_bresp,    // Write response
	output logic                      s_axi_bvalid,   // Write response valid
	input  wire logic                 s_axi_bready,   // Write response ready
	input  wire logic [11:0]          s_axi_araddr,   // Read address
	input  wire logic                 s_axi_arvalid,  // Read address valid
	output logic                      s_axi_arready,  // Read address ready
	output logic [31:0]               s_axi_rdata,    // Read data
	output logic [1:0]                s_axi_rresp,    // Read response
	output logic                      s_axi_rvalid,   // Read data valid
	input  wire logic                 s_axi_rready,   // Read data ready
	output logic [1:0]                phaseErrorOut,  // Per-decoder phase error
	output logic                      timerErrIn_n,   // Inverted selected error
	output logic [15:0]               position0,      // Decoder 0 position count
	output logic [15:0]               position1,      // Decoder 1 position count
	output logic [1:0]                compareSync,    // Position compare sync pulse
	output logic                      irq             // Level interrupt
);
	import quad_integ_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Register file
	//   000 clock disable, bit 9 stops the decoder clock domain only
	//   004 input path select, sync bits 0/8/16/24, filter bits 1/9/17/25
	//   008 error select, bit 0 picks which decoder reaches the timer input
	//   00c status, write one to clear: [1:0] phase error, [3:2] compare sync
	//   010 interrupt mask, same layout as status
	//   014 filter width in cycles, bits [3:0]
	// Any other address answers with a slave error and changes nothing

	// Only the low nibble of status, mask and filter width is stored
	logic [31:0] clkDis_reg,  clkDis_next;
	logic [31:0] pathSel_reg, pathSel_next;
	logic        errSel_reg,  errSel_next;
	logic [3:0]  status_reg,  status_next;
	logic [3:0]  mask_reg,    mask_next;
	logic [3:0]  filtW_reg,   filtW_next;
	logic        bvalid_reg,  bvalid_next;
	logic        rvalid_reg,  rvalid_next;
	logic [1:0]  bresp_reg,   bresp_next;
	logic [1:0]  rresp_reg,   rresp_next;
	logic [31:0] rdata_reg,   rdata_next;
	logic [3:0]  events;
	logic        qdecEn;
	logic        wrFire;
	logic        rdFire;

	// Offsets that hold a register; all others answer with a slave error
	function automatic logic [1:0] respFor(input logic [11:0] a);
		unique case (a)
			`OFS_CLKDIS, `OFS_PATHSEL, `OFS_ERRSEL,
			`OFS_STATUS, `OFS_MASK, `OFS_FILTW: return 2'b00;
			default:                            return 2'b10;
		endcase
	endfunction

	// Byte-lane merge of a write into a stored word
	// Lanes whose strobe is low keep their old byte
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int k = 0; k < 4; k++) begin
			if (s[k]) begin
				r[k*8 +: 8] = d[k*8 +: 8];
			end
		end
		return r;
	endfunction

	// Both write channels are taken together, so order on the bus never matters.
	// Nothing is taken while the block is frozen, else a write would be lost.
	assign wrFire        = clkEnable && s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
	assign rdFire        = clkEnable && s_axi_arvalid && !rvalid_reg;
	assign s_axi_awready = wrFire;
	assign s_axi_wready  = wrFire;
	assign s_axi_arready = rdFire;

	// Decoder clock runs unless the disable bit is set. Gating is an enable on the
	// decoder flops rather than a cut clock, so no glitch reaches them; the register
	// file and the interrupt logic stay awake so software can always undo the gate.
	assign qdecEn = clkEnable && !clkDis_reg[`BIT_QDEC_CLKDIS];

	always_comb begin
		clkDis_next  = clkDis_reg;
		pathSel_next = pathSel_reg;
		errSel_next  = errSel_reg;
		mask_next    = mask_reg;
		filtW_next   = filtW_reg;
		status_next  = status_reg;
		bvalid_next  = bvalid_reg && !s_axi_bready;
		rvalid_next  = rvalid_reg && !s_axi_rready;
		bresp_next   = bresp_reg;
		rresp_next   = rresp_reg;
		rdata_next   = rdata_reg;
		if (wrFire) begin
			bvalid_next = 1'b1;
			bresp_next  = respFor(s_axi_awaddr);
			unique case (s_axi_awaddr)
				`OFS_CLKDIS:  clkDis_next  = merge(clkDis_reg, s_axi_wdata, s_axi_wstrb);
				`OFS_PATHSEL: pathSel_next = merge(pathSel_reg, s_axi_wdata, s_axi_wstrb);
				`OFS_ERRSEL:  errSel_next  = s_axi_wstrb[0] ? s_axi_wdata[0] : errSel_reg;
				`OFS_STATUS:  status_next  = status_reg & ~(s_axi_wstrb[0] ? s_axi_wdata[3:0] : 4'h0);
				`OFS_MASK:    mask_next    = s_axi_wstrb[0] ? s_axi_wdata[3:0] : mask_reg;
				`OFS_FILTW:   filtW_next   = s_axi_wstrb[0] ? s_axi_wdata[3:0] : filtW_reg;
				default:      bresp_next   = 2'b10;
			endcase
		end
		// Set wins over a same-cycle write-one clear,
		// so an event landing on the clear cycle is never lost
		status_next = status_next | events;
		if (rdFire) begin
			rvalid_next = 1'b1;
			rresp_next  = respFor(s_axi_araddr);
			unique case (s_axi_araddr)
				`OFS_CLKDIS:  rdata_next = clkDis_reg;
				`OFS_PATHSEL: rdata_next = pathSel_reg;
				`OFS_ERRSEL:  rdata_next = {31'h0, errSel_reg};
				`OFS_STATUS:  rdata_next = {28'h0, status_reg};
				`OFS_MASK:    rdata_next = {28'h0, mask_reg};
				`OFS_FILTW:   rdata_next = {28'h0, filtW_reg};
				default: begin
					rdata_next = 32'h0;
					rresp_next = 2'b10;
				end
			endcase
		end
	end

	// Clock disable resets to zero so the decoders run from the start
	// clkEnable low holds every register, responses included
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			clkDis_reg  <= `RST_CLKDIS;
			pathSel_reg <= `RST_PATHSEL;
			errSel_reg  <= 1'b0;
			status_reg  <= 4'h0;
			mask_reg    <= 4'h0;
			filtW_reg   <= `RST_FILTW;
			bvalid_reg  <= 1'b0;
			rvalid_reg  <= 1'b0;
			bresp_reg   <= 2'b00;
			rresp_reg   <= 2'b00;
			rdata_reg   <= 32'h0;
		end else if (clkEnable) begin
			clkDis_reg  <= clkDis_next;
			pathSel_reg <= pathSel_next;
			errSel_reg  <= errSel_next;
			status_reg  <= status_next;
			mask_reg    <= mask_next;
			filtW_reg   <= filtW_next;
			bvalid_reg  <= bvalid_next;
			rvalid_reg  <= rvalid_next;
			bresp_reg   <= bresp_next;
			rresp_reg   <= rresp_next;
			rdata_reg   <= rdata_next;
		end
	end

	// Responses come straight from flops; irq is a level over unmasked status
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp  = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp  = rresp_reg;
	assign s_axi_rdata  = rdata_reg;
	assign irq          = |(status_reg & mask_reg);

	////////////////////////////////////////////////////////////////////////////////
	// Input conditioning

	// Path choice: sync bit wins, else filter bit, else PATH_RAW, which the mux below maps to the sync pin.
	// Both select bits low is not a listed setting; it falls back to the sync path
	// rather than passing the raw pin, which would let metastability through.
	function automatic path_t pick(input logic syncBit, input logic filtBit);
		if (syncBit) begin
			return PATH_SYNC;
		end else if (filtBit) begin
			return PATH_FILT;
		end
		return PATH_RAW;
	endfunction

	// Pins are packed strobe, index, B, A from the top, four decoders each;
	// bits of decoders 2 and 3 are conditioned but no core reads them
	logic [15:0] rawPins;
	logic [15:0] syncPins;
	logic [15:0] filtPins;
	logic [15:0] condPins;
	path_t       selPath [4];

	assign rawPins = {pinsS, pinsI, pinsB, pinsA};
	// One path choice per pin group: A, B, index, strobe
	assign selPath[0] = pick(pathSel_reg[`BIT_A_SYNC], pathSel_reg[`BIT_A_FILT]);
	assign selPath[1] = pick(pathSel_reg[`BIT_B_SYNC], pathSel_reg[`BIT_B_FILT]);
	assign selPath[2] = pick(pathSel_reg[`BIT_I_SYNC], pathSel_reg[`BIT_I_FILT]);
	assign selPath[3] = pick(pathSel_reg[`BIT_S_SYNC], pathSel_reg[`BIT_S_FILT]);

	// Latency from a pin to the decoder input:
	//   sync path      two edges through the synchroniser
	//   filtered path  two edges plus filter width plus one for the compare
	// The decoder register adds one more edge, so a count follows its pin edge
	// after three edges on the sync path, inside the four-cycle budget.
	// Index and strobe pulses must outlast sync plus filter, else they vanish
	generate
		for (genvar g = 0; g < 16; g++) begin : gCond
			input_conditioner uCond (
				.clk_sys   (clk_sys),
				.sys_rst   (sys_rst),
				.clkEn     (qdecEn),
				.pinIn     (rawPins[g]),
				.filtWidth (filtW_reg),
				.syncOut   (syncPins[g]),
				.filtOut   (filtPins[g])
			);
			always_comb begin
				unique case (selPath[g / 4])
					PATH_SYNC: condPins[g] = syncPins[g];
					PATH_FILT: condPins[g] = filtPins[g];
					default:   condPins[g] = syncPins[g];
				endcase
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Decoder cores

	// Per-decoder state: last phase pair, count, pulses and the last index level
	logic [1:0]  prevAB_reg [2];
	logic [1:0]  prevAB_next [2];
	logic [15:0] pos_reg [2];
	logic [15:0] pos_next [2];
	logic [1:0]  perr_reg, perr_next;
	logic [1:0]  cmp_reg,  cmp_next;
	logic [1:0]  idxPrev_reg, idxPrev_next;

	// Forward when the old phase A level differs from the new phase B level
	function automatic logic stepFwd(input logic [1:0] prev, input logic [1:0] cur);
		return prev[0] ^ cur[1];
	endfunction

	// One phase moved: the parity of the pair flips on every legal step
	function automatic logic oneStep(input logic [1:0] prev, input logic [1:0] cur);
		return (prev[1] ^ prev[0]) != (cur[1] ^ cur[0]);
	endfunction

	// Gray-order step: +1 forward, -1 reverse, both bits flipping is illegal.
	// An illegal step leaves the count alone: no direction can be told from it.
	// The error and compare sync flags are single-cycle pulses of the decoder clock.
	always_comb begin
		for (int d = 0; d < 2; d++) begin
			logic [1:0] cur;
			cur            = {condPins[4 + d], condPins[d]};
			prevAB_next[d] = cur;
			pos_next[d]    = pos_reg[d];
			perr_next[d]   = 1'b0;
			cmp_next[d]    = 1'b0;
			idxPrev_next[d] = condPins[8 + d];
			if ((cur ^ prevAB_reg[d]) == 2'b11) begin
				perr_next[d] = 1'b1;
			end else if (cur != prevAB_reg[d]) begin
				if (oneStep(prevAB_reg[d], cur)) begin
					pos_next[d] = stepFwd(prevAB_reg[d], cur) ? pos_reg[d] + 16'h1 : pos_reg[d] - 16'h1;
				end
			end
			// Rising index edge resets position and fires a compare sync
			if (condPins[8 + d] && !idxPrev_reg[d]) begin
				pos_next[d] = 16'h0;
				cmp_next[d] = 1'b1;
			end
		end
		// Status events: [1:0] phase error, [3:2] compare sync
		events = {cmp_reg, perr_reg};
	end

	// Decoder state advances only while the decoder clock domain runs
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			prevAB_reg[0] <= 2'b00;
			prevAB_reg[1] <= 2'b00;
			pos_reg[0]    <= 16'h0;
			pos_reg[1]    <= 16'h0;
			perr_reg      <= 2'b00;
			cmp_reg       <= 2'b00;
			idxPrev_reg   <= 2'b00;
		end else if (qdecEn) begin
			prevAB_reg[0] <= prevAB_next[0];
			prevAB_reg[1] <= prevAB_next[1];
			pos_reg[0]    <= pos_next[0];
			pos_reg[1]    <= pos_next[1];
			perr_reg      <= perr_next;
			cmp_reg       <= cmp_next;
			idxPrev_reg   <= idxPrev_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	// Error toward the timer is active low so a quiet line reads high.
	// Position counts are plain flops; a coherent software copy would need a snapshot.
	assign phaseErrorOut = perr_reg;
	assign timerErrIn_n  = ~perr_reg[errSel_reg];
	assign position0     = pos_reg[0];
	assign position1     = pos_reg[1];
	assign compareSync   = cmp_reg;
endmodule

// ===== src/quad_integ_defs.svh
`ifndef QUAD_INTEG_DEFS_SVH
`define QUAD_INTEG_DEFS_SVH

// Register byte offsets
`define OFS_CLKDIS      12'h000
`define OFS_PATHSEL     12'h004
`define OFS_ERRSEL      12'h008
`define OFS_STATUS      12'h00c
`define OFS_MASK        12'h010
`define OFS_FILTW       12'h014

// Field positions
`define BIT_QDEC_CLKDIS 9
`define BIT_A_SYNC      0
`define BIT_A_FILT      1
`define BIT_B_SYNC      8
`define BIT_B_FILT      9
`define BIT_I_SYNC      16
`define BIT_I_FILT      17
`define BIT_S_SYNC      24
`define BIT_S_FILT      25

// Reset values
`define RST_CLKDIS      32'h0000_0000
`define RST_PATHSEL     32'h0101_0101
`define RST_FILTW       4'h3

// Timing figures in peripheral clock cycles
`define CNT_INC_MAX_CYC 4
`define PCS_MAX_CYC     6

`endif

// ===== src/quad_integ_pkg.sv
package quad_integ_pkg;
	typedef enum logic [1:0] {
		PATH_RAW    = 2'b00,
		PATH_SYNC   = 2'b01,
		PATH_FILT   = 2'b10
	} path_t;
	typedef logic [3:0] pins_t;
	typedef enum logic [1:0] {
		QS0 = 2'b00,
		QS1 = 2'b01,
		QS2 = 2'b11,
		QS3 = 2'b10
	} quad_t;
endpackage

// ===== src/input_conditioner.sv
`include "quad_integ_defs.svh"

// Two-stage synchroniser followed by a stability filter for one encoder pin
module input_conditioner (
	input  wire logic       clk_sys,    // Peripheral clock
	input  wire logic       sys_rst,    // Async reset, high
	input  wire logic       clkEn,      // Gated clock enable
	input  wire logic       pinIn,      // Raw pin
	input  wire logic [3:0] filtWidth,  // Cycles a level must hold
	output logic            syncOut,    // Synchronised only
	output logic            filtOut     // Synchronised and filtered
);
	import quad_integ_pkg::*;

	logic       meta_reg,  meta_next;
	logic       sync_reg,  sync_next;
	logic       filt_reg,  filt_next;
	logic [3:0] cnt_reg,   cnt_next;

	// Filter waits for a level to stand filtWidth cycles before passing it
	always_comb begin
		meta_next = pinIn;
		sync_next = meta_reg;
		filt_next = filt_reg;
		cnt_next  = 4'h0;
		if (sync_reg != filt_reg) begin
			if (cnt_reg >= filtWidth) begin
				filt_next = sync_reg;
			end else begin
				cnt_next = cnt_reg + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			filt_reg <= 1'b0;
			cnt_reg  <= 4'h0;
		end else if (clkEn) begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
			filt_reg <= filt_next;
			cnt_reg  <= cnt_next;
		end
	end

	assign syncOut = sync_reg;
	assign filtOut = filt_reg;
endmodule

// ===== test/quad_integ_props.sv
`include "quad_integ_defs.svh"

// Port-side checks of the decoder integration
module quad_integ_props (
	input wire logic                  clk_sys,       // Clock
	input wire logic                  sys_rst,       // Reset
	input wire logic                  clkEnable,     // Run enable
	input wire quad_integ_pkg::pins_t pinsA,         // Phase A
	input wire quad_integ_pkg::pins_t pinsB,         // Phase B
	input wire quad_integ_pkg::pins_t pinsI,         // Index
	input wire logic [11:0]           s_axi_awaddr,  // Write address
	input wire logic                  s_axi_awvalid, // Aw valid
	input wire logic                  s_axi_awready, // Aw ready
	input wire logic [31:0]           s_axi_wdata,   // Write data
	input wire logic                  s_axi_wvalid,  // W valid
	input wire logic                  s_axi_wready,  // W ready
	input wire logic                  s_axi_bvalid,  // B valid
	input wire logic                  s_axi_arvalid, // Ar valid
	input wire logic                  s_axi_arready, // Ar ready
	input wire logic                  s_axi_rvalid,  // R valid
	input wire logic [1:0]            phaseErrorOut, // Phase errors
	input wire logic                  timerErrIn_n,  // Inverted error
	input wire logic [15:0]           position0,     // Count 0
	input wire logic [15:0]           position1,     // Count 1
	input wire logic [1:0]            compareSync    // Compare sync
);
	logic phSync_reg;
	logic ixSync_reg;
	logic clkOff_reg;
	wire  wrTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire  run    = clkEnable && !clkOff_reg;

	// Shadow the path and gate bits: the filter path adds delay beyond the sync bounds
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			phSync_reg <= 1'b1;
			ixSync_reg <= 1'b1;
			clkOff_reg <= 1'b0;
		end else if (wrTake && s_axi_awaddr == `OFS_PATHSEL) begin
			phSync_reg <= s_axi_wdata[`BIT_A_SYNC] | ~s_axi_wdata[`BIT_A_FILT];
			ixSync_reg <= s_axi_wdata[`BIT_I_SYNC] | ~s_axi_wdata[`BIT_I_FILT];
		end else if (wrTake && s_axi_awaddr == `OFS_CLKDIS) begin
			clkOff_reg <= s_axi_wdata[`BIT_QDEC_CLKDIS];
		end
	end

	////////////////////////////////////////
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	sequence bothMove;
		$changed(pinsA[0]) && $changed(pinsB[0]) && run;
	endsequence
	sequence gatedTwo;
		clkOff_reg ##1 clkOff_reg;
	endsequence

	inv_idle_a: assert property (phaseErrorOut == 2'b00 |-> timerErrIn_n)
		else $error("error input low while no error");
	inv_cause_a: assert property (!timerErrIn_n |-> phaseErrorOut != 2'b00)
		else $error("error input low without cause");
	phase_err_a: assert property (bothMove |-> ##[1:12] phaseErrorOut[0])
		else $error("illegal step not flagged");
	err_pulse_a: assert property (phaseErrorOut[0] |=> !phaseErrorOut[0])
		else $error("phase error longer than one cycle");
	count_delay_a: assert property ($changed(pinsA[0]) && $stable(pinsB[0]) && phSync_reg && run
		|-> ##[1:4] $changed(position0)) else $error("count late");
	index_sync_a: assert property ($rose(pinsI[0]) && ixSync_reg && run |-> ##[1:6] compareSync[0])
		else $error("compare sync late");
	gate_hold_a: assert property (gatedTwo |-> $stable(position0) && $stable(position1))
		else $error("count moved while gated");
	wr_answer_a: assert property (wrTake |=> s_axi_bvalid)
		else $error("no write response");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read response");
endmodule

bind quad_decoder_integration quad_integ_props i_props (.*);

// ===== test/encoder_model.sv
// Incremental encoder driving the pins of two decoders
module encoder_model #(
	parameter int FILT_W = 3 // Filter width that every pulse level covers
) (
	input  wire logic             clk_sys, // Clock
	output quad_integ_pkg::pins_t pinsA,   // Phase A
	output quad_integ_pkg::pins_t pinsB,   // Phase B
	output quad_integ_pkg::pins_t pinsI,   // Index
	output quad_integ_pkg::pins_t pinsS    // Strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] st [2] = '{2'b00, 2'b00};

	// Lines idle low
	initial begin
		{pinsA, pinsB, pinsI, pinsS} = '0;
	end

	// Gray step; a step of 2 moves both phases, an illegal move
	task automatic step(input int d, input int dir, input int hold);
		st[d] = st[d] + 2'(dir);
		pinsA[d] <= st[d][1];
		pinsB[d] <= st[d][1] ^ st[d][0];
		repeat (hold) @(posedge clk_sys);
	endtask

	// Short spike on phase A, shorter than the filter if asked
	task automatic glitch(input int d, input int w, input int hold);
		pinsA[d] <= ~pinsA[d];
		repeat (w) @(posedge clk_sys);
		pinsA[d] <= ~pinsA[d];
		repeat (hold) @(posedge clk_sys);
	endtask

	// Index or strobe pulse; levels never shorter than the filtered minimum
	task automatic pulse(input int d, input bit idx, input int hi, input int lo);
		int h;
		int l;
		h = (hi < 2 + FILT_W) ? 2 + FILT_W : hi;
		l = (lo < 2 + FILT_W) ? 2 + FILT_W : lo;
		if (idx) pinsI[d] <= 1'b1; else pinsS[d] <= 1'b1;
		repeat (h) @(posedge clk_sys);
		if (idx) pinsI[d] <= 1'b0; else pinsS[d] <= 1'b0;
		repeat (l) @(posedge clk_sys);
	endtask
endmodule

// ===== test/test_quad_decoder_integration.sv
`include "quad_integ_defs.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module test_quad_decoder_integration;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  clk_sys = 1'b0;
	logic                  sys_rst = 1'b1;
	logic                  clkEnable = 1'b1;
	quad_integ_pkg::pins_t pinsA, pinsB, pinsI, pinsS;
	logic [11:0]           s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0]           s_axi_wdata = '0, s_axi_rdata, rd;
	logic [3:0]            s_axi_wstrb = 4'hf;
	logic                  s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, timerErrIn_n, irq;
	logic [1:0]            s_axi_bresp, s_axi_rresp, phaseErrorOut, compareSync, rr, br;
	logic [15:0]           position0, position1;
	int                    error_cnt = 0, num_checks = 0, errLow = 0, csCnt = 0;
	int                    expPos [2] = '{0, 0};

	quad_decoder_integration i_dut (.*);
	encoder_model i_enc (.clk_sys, .pinsA, .pinsB, .pinsI, .pinsS);

	always #10 clk_sys = ~clk_sys;

	// Count error and compare-sync pulses as they pass
	always @(posedge clk_sys) begin
		if (timerErrIn_n === 1'b0) errLow++;
		csCnt += $countones(compareSync);
	end

	////////////////////////////////////////
	task automatic axiWr(input logic [11:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		br = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic axiRd(input logic [11:0] a, input logic [31:0] e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge clk_sys);
		`CHK("rdata", e, rd)
	endtask

	task automatic chkPos();
		`CHK("position0", expPos[0][15:0], position0)
		`CHK("position1", expPos[1][15:0], position1)
	endtask

	// Irq is looked at only after the mask or status write has settled
	task automatic chkIrq(input logic e);
		repeat (2) @(posedge clk_sys);
		`CHK("irq", e, irq)
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////
	initial begin
		int n;
		int d;
		int m;
		n = $urandom(64528);
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		axiRd(`OFS_CLKDIS, `RST_CLKDIS);
		axiRd(`OFS_PATHSEL, `RST_PATHSEL);
		axiRd(`OFS_FILTW, {28'h0, `RST_FILTW});
		axiRd(12'h01c, 32'h0);
		`CHK("rresp", 2'b10, rr)
		// Random legal steps on both decoders, sync path
		for (n = 0; n < 24; n++) begin
			d = $urandom % 2;
			m = ($urandom % 2) ? 1 : -1;
			i_enc.step(d, m, 6);
			expPos[d] += m;
			chkPos();
		end
		// Illegal steps against every error selection
		axiWr(`OFS_MASK, 32'h0);
		for (n = 0; n < 4; n++) begin
			d = n % 2;
			axiWr(`OFS_ERRSEL, 32'(n / 2));
			m = errLow;
			i_enc.step(d, 2, 12);
			`CHK("errsel", int'(n / 2 == d), errLow - m)
		end
		axiRd(`OFS_STATUS, 32'h3);
		chkIrq(1'b0);
		axiWr(`OFS_MASK, 32'h3);
		chkIrq(1'b1);
		axiWr(`OFS_STATUS, 32'h3);
		chkIrq(1'b0);
		// Index zeroes both counts; strobe alone raises no compare sync
		m = csCnt;
		for (d = 0; d < 2; d++) begin
			i_enc.pulse(d, 1'b1, 2, 6);
			expPos[d] = 0;
		end
		i_enc.pulse(0, 1'b0, 2, 6);
		`CHK("compare sync", m + 2, csCnt)
		chkPos();
		axiRd(`OFS_STATUS, 32'hc);
		axiWr(`OFS_MASK, 32'h4);
		chkIrq(1'b1);
		axiWr(`OFS_STATUS, 32'hc);
		chkIrq(1'b0);
		// Filtered path: a spike shorter than the filter is dropped, a held step counts
		axiWr(`OFS_PATHSEL, 32'h0202_0202);
		i_enc.glitch(0, 2, 14);
		chkPos();
		i_enc.step(0, 1, 16);
		expPos[0]++;
		chkPos();
		axiWr(`OFS_PATHSEL, `RST_PATHSEL);
		// Gated decoder clock holds the count until released
		axiWr(`OFS_CLKDIS, 32'h200);
		i_enc.step(1, 1, 10);
		chkPos();
		axiRd(`OFS_CLKDIS, 32'h200);
		axiWr(`OFS_CLKDIS, 32'h0);
		repeat (8) @(posedge clk_sys);
		expPos[1]++;
		chkPos();
		// Frozen block: a step waits for clkEnable, then counts
		clkEnable <= 1'b0;
		i_enc.step(0, 1, 6);
		chkPos();
		clkEnable <= 1'b1;
		repeat (4) @(posedge clk_sys);
		expPos[0]++;
		chkPos();
		axiWr(12'h01c, 32'h0);
		`CHK("bresp", 2'b10, br)
		finish_test();
	end

	// Watchdog far beyond the few hundred cycles the sequence needs
	initial begin
		repeat (30000) @(posedge clk_sys);
		error_cnt++;
		finish_test();
	end
endmodule
